// file: core/ckcrc_pkg.sv
/*
  Constants, register indices and state types for the colour-key range store and
  video signature block.
  Assumes an AHB-Lite host with 32-bit data and one register per aligned word.
*/
// Contract
// - four fields (overlay, red, green, blue) each own lower and upper key bounds.
// - bounds are eight bits, any value 0..0xff, read/write, no reset value.
// - lower bounds at even indices 0x30..0x36, upper bounds at following odd ones.
// - 16-bit signature readable as low byte at 0x3c, high byte at 0x3d.
// - signature bytes have no reset value; reads never disturb accumulation.
// - two hsync pulses during blanking transfer the accumulator into the result.
// - accumulator advances only on active pixels; blanking pauses it.
// - write-only line select at 0x3e, no reset value, writable any time.
// - codes 0x00-0x17 pick red, green, blue bits 0..7; upper bits reserved.
// - per-field compare enables gate keying; all disabled after reset.
// - polarity picks true or complementary keying; complementary after reset.
`default_nettype none

package ckcrc_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DAC_WIDTH   = 24;
  localparam int CRC_WIDTH   = 16;
  localparam int CODE_WIDTH  = 5;
  localparam int REG_WIDTH   = 8;
  localparam int FIELD_COUNT = 4;
  localparam int BOUND_COUNT = 8;
  localparam int DIV_WIDTH   = 8;
  localparam int INDEX_LSB   = 2;
  localparam int INDEX_MSB   = 9;

  // ----------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_OVERLAY_KEY_LOWER     = 8'h30;
  localparam logic [7:0] IDX_OVERLAY_KEY_UPPER     = 8'h31;
  localparam logic [7:0] IDX_RED_KEY_LOWER         = 8'h32;
  localparam logic [7:0] IDX_RED_KEY_UPPER         = 8'h33;
  localparam logic [7:0] IDX_GREEN_KEY_LOWER       = 8'h34;
  localparam logic [7:0] IDX_GREEN_KEY_UPPER       = 8'h35;
  localparam logic [7:0] IDX_BLUE_KEY_LOWER        = 8'h36;
  localparam logic [7:0] IDX_BLUE_KEY_UPPER        = 8'h37;
  localparam logic [7:0] IDX_KEY_CONTROL           = 8'h38;
  localparam logic [7:0] IDX_SIGNATURE_LOW_BYTE    = 8'h3c;
  localparam logic [7:0] IDX_SIGNATURE_HIGH_BYTE   = 8'h3d;
  localparam logic [7:0] IDX_SIGNATURE_LINE_SELECT = 8'h3e;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int         ENABLE_LSB           = 0;
  localparam int         ENABLE_MSB           = 3;
  localparam int         POLARITY_BIT         = 4;
  localparam logic [3:0] COMPARE_ENABLE_RESET = 4'h0;
  localparam logic       KEY_POLARITY_RESET   = 1'h1;
  localparam logic [1:0] HTRANS_NONSEQ        = 2'h2;
  localparam logic       HRESP_OKAY           = 1'h0;
  localparam logic [1:0] RETRACE_HSYNC_LAST   = 2'h1;
  localparam logic [15:0] CRC_POLY_DEFAULT    = 16'h1021;
  localparam logic [15:0] CRC_SEED_DEFAULT    = 16'h0000;
  localparam logic [7:0] PIXEL_DIV_DEFAULT    = 8'h01;

  // ----------------------------------------------------------------
  // state of the register and video control module
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                                dataPhase;
    logic                                phaseWrite;
    logic [7:0]                          phaseIndex;
    logic [BOUND_COUNT-1:0][REG_WIDTH-1:0] keyBound;
    logic [FIELD_COUNT-1:0]              compareEnable;
    logic                                keyPolarity;
    logic [CODE_WIDTH-1:0]               lineCode;
    logic [REG_WIDTH-1:0]                readData;
    logic [1:0]                          hsyncCount;
    logic                                retraceDone;
    logic                                lastHsync;
    logic [DIV_WIDTH-1:0]                pixelDiv;
  } ckcrc_ctrl_t;

endpackage

`default_nettype wire

// file: core/ckcrc_vid_if.sv
/*
  Signals between the control logic and the signature engine.
  Assumes both ends run on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

interface ckcrc_vid_if;
  logic        advance;
  logic        pixelBit;
  logic        capture;
  logic [15:0] signature;

  modport ctrl   (output advance, output pixelBit, output capture, input signature);
  modport engine (input advance, input pixelBit, input capture, output signature);
endinterface

`default_nettype wire

// file: core/ckcrc_sync.sv
/*
  Three-stage synchroniser with agreement filter for video pins.
  Assumes inputs are asynchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module ckcrc_sync #(
  parameter int WIDTH = 26
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // pins and filtered result
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] stableOut
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] stable;
  } ckcrc_sync_t;

  ckcrc_sync_t s;
  ckcrc_sync_t next_s;

  // ----------------------------------------------------------------
  // stage chain; a change counts when stage 2 and 3 agree
  // ----------------------------------------------------------------
  always_comb begin
    next_s        = s;
    next_s.stage1 = pinIn;
    next_s.stage2 = s.stage1;
    next_s.stage3 = s.stage2;
    for (int i = 0; i < WIDTH; i++) begin
      if (s.stage2[i] == s.stage3[i]) begin
        next_s.stable[i] = s.stage3[i];
      end
    end
    if (!reset_n) begin
      next_s.stable = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    s <= next_s;
  end

  assign stableOut = s.stable;

endmodule

`default_nettype wire

// file: core/ckcrc_sig.sv
/*
  Serial signature engine: accumulator and result register.
  Assumes advance and capture never coincide (capture needs blanking).
*/
`timescale 1ns/1ps
`default_nettype none

module ckcrc_sig
  import ckcrc_pkg::*;
#(
  parameter logic [CRC_WIDTH-1:0] CRC_POLY = CRC_POLY_DEFAULT,
  parameter logic [CRC_WIDTH-1:0] CRC_SEED = CRC_SEED_DEFAULT
) (
  // clock and reset
  input  wire logic   ref_clk,
  input  wire logic   reset_n,
  // control side
  ckcrc_vid_if.engine vid
);

  typedef struct packed {
    logic [CRC_WIDTH-1:0] accum;
    logic [CRC_WIDTH-1:0] result;
  } ckcrc_sig_t;

  ckcrc_sig_t s;
  ckcrc_sig_t next_s;

  // msb-first shift, feedback xor with polynomial
  function automatic logic [CRC_WIDTH-1:0] crcStep(input logic [CRC_WIDTH-1:0] crc, input logic din);
    logic fb;
    fb = din ^ crc[CRC_WIDTH-1];
    return {crc[CRC_WIDTH-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
  endfunction

  // ----------------------------------------------------------------
  // accumulate and transfer
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    if (vid.advance) begin
      next_s.accum = crcStep(s.accum, vid.pixelBit);
    end
    if (vid.capture) begin
      next_s.result = s.accum;
      next_s.accum  = CRC_SEED;
    end
    if (!reset_n) begin
      next_s.accum = CRC_SEED; // result keeps no reset value
    end
  end

  always_ff @(posedge ref_clk) begin
    s <= next_s;
  end

  assign vid.signature = s.result;

endmodule

`default_nettype wire

// file: core/ckcrc_top.sv
/*
  Colour-key range registers, key control and video signature block with an
  AHB-Lite register slave.
  Assumes video pins are asynchronous, the slave is the only one on its bus and
  transfers are single whole words.
*/
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module ckcrc_top
  import ckcrc_pkg::*;
#(
  parameter logic [CRC_WIDTH-1:0] CRC_POLY    = CRC_POLY_DEFAULT,
  parameter logic [CRC_WIDTH-1:0] CRC_SEED    = CRC_SEED_DEFAULT,
  parameter logic [DIV_WIDTH-1:0] PIXEL_DIVIDE = PIXEL_DIV_DEFAULT
) (
  // clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          reset_n,
  // ahb-lite slave
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  // video pins
  input  wire logic [DAC_WIDTH-1:0]          vidData,
  input  wire logic                          vidHsync,
  input  wire logic                          vidBlank,
  // key settings to the keyer
  output logic      [FIELD_COUNT-1:0][7:0]   keyLower,
  output logic      [FIELD_COUNT-1:0][7:0]   keyUpper,
  output logic      [FIELD_COUNT-1:0]        compareEnable,
  output logic                               keyPolarity,
  // signature
  output logic      [CRC_WIDTH-1:0]          signature
);

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic logic isKeyIndex(input logic [7:0] idx);
    return (idx >= IDX_OVERLAY_KEY_LOWER) && (idx <= IDX_BLUE_KEY_UPPER);
  endfunction

  // slot 0 overlay lower, 1 overlay upper, 2 red lower ... 7 blue upper
  function automatic logic [2:0] keySlot(input logic [7:0] idx);
    logic [7:0] diff;
    diff = idx - IDX_OVERLAY_KEY_LOWER;
    return diff[2:0];
  endfunction

  function automatic logic [7:0] readMux(input logic [7:0] idx, input ckcrc_ctrl_t st,
                                         input logic [CRC_WIDTH-1:0] sig);
    logic [7:0] val;
    val = 8'h00;
    if (isKeyIndex(idx)) begin
      val = st.keyBound[keySlot(idx)];
    end else if (idx == IDX_KEY_CONTROL) begin
      val[ENABLE_MSB:ENABLE_LSB] = st.compareEnable;
      val[POLARITY_BIT]          = st.keyPolarity;
    end else if (idx == IDX_SIGNATURE_LOW_BYTE) begin
      val = sig[7:0];
    end else if (idx == IDX_SIGNATURE_HIGH_BYTE) begin
      val = sig[15:8];
    end
    return val;
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [DAC_WIDTH+1:0] pinRaw;
  logic [DAC_WIDTH+1:0] pinStable;
  logic [DAC_WIDTH-1:0] pixData;
  logic                 pixHsync;
  logic                 pixBlank;

  assign pinRaw = {vidBlank, vidHsync, vidData};

  ckcrc_sync #(
    .WIDTH (DAC_WIDTH + 2)
  ) u_sync (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .pinIn     (pinRaw),
    .stableOut (pinStable)
  );

  assign pixData  = pinStable[DAC_WIDTH-1:0];
  assign pixHsync = pinStable[DAC_WIDTH];
  assign pixBlank = pinStable[DAC_WIDTH+1];

  // ----------------------------------------------------------------
  // signature engine
  // ----------------------------------------------------------------
  ckcrc_vid_if vid ();

  ckcrc_sig #(
    .CRC_POLY (CRC_POLY),
    .CRC_SEED (CRC_SEED)
  ) u_sig (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .vid     (vid)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ckcrc_ctrl_t s;
  ckcrc_ctrl_t next_s;
  logic        addrTaken;
  logic        hsyncRise;
  logic        pixelTick;
  logic        captureNow;
  logic        selectBit;

  always_comb begin
    next_s     = s;
    addrTaken  = 1'b0;
    hsyncRise  = 1'b0;
    pixelTick  = 1'b0;
    captureNow = 1'b0;
    selectBit  = 1'b0;

    // ---------------------------------------------------------------
    // data phase: writes land here
    // ---------------------------------------------------------------
    if (s.dataPhase && s.phaseWrite) begin
      if (isKeyIndex(s.phaseIndex)) begin
        next_s.keyBound[keySlot(s.phaseIndex)] = hwdata[REG_WIDTH-1:0];
      end else if (s.phaseIndex == IDX_KEY_CONTROL) begin
        next_s.compareEnable = hwdata[ENABLE_MSB:ENABLE_LSB];
        next_s.keyPolarity   = hwdata[POLARITY_BIT];
      end else if (s.phaseIndex == IDX_SIGNATURE_LINE_SELECT) begin
        next_s.lineCode = hwdata[CODE_WIDTH-1:0]; // reserved bits dropped
      end
    end

    // ---------------------------------------------------------------
    // address phase: capture, read data from post-write copy
    // ---------------------------------------------------------------
    addrTaken             = hsel && hready && (htrans == HTRANS_NONSEQ);
    next_s.dataPhase      = addrTaken;
    next_s.phaseWrite     = hwrite;
    next_s.phaseIndex     = haddr[INDEX_MSB:INDEX_LSB];
    if (addrTaken && !hwrite) begin
      next_s.readData = readMux(haddr[INDEX_MSB:INDEX_LSB], next_s, vid.signature);
    end

    // ---------------------------------------------------------------
    // pixel rate enable
    // ---------------------------------------------------------------
    if (s.pixelDiv >= PIXEL_DIVIDE - 8'h01) begin
      pixelTick       = 1'b1;
      next_s.pixelDiv = '0;
    end else begin
      next_s.pixelDiv = s.pixelDiv + 8'h01;
    end

    // ---------------------------------------------------------------
    // line select; codes beyond 23 feed zero
    // ---------------------------------------------------------------
    if (s.lineCode < CODE_WIDTH'(DAC_WIDTH)) begin
      selectBit = pixData[s.lineCode];
    end

    // ---------------------------------------------------------------
    // retrace detection: second hsync in one blanking period
    // ---------------------------------------------------------------
    next_s.lastHsync = pixHsync;
    hsyncRise        = pixHsync && !s.lastHsync;
    if (!pixBlank) begin
      next_s.hsyncCount  = '0;
      next_s.retraceDone = 1'b0;
    end else if (hsyncRise && !s.retraceDone) begin
      if (s.hsyncCount == RETRACE_HSYNC_LAST) begin
        captureNow         = 1'b1;
        next_s.retraceDone = 1'b1;
        next_s.hsyncCount  = '0;
      end else begin
        next_s.hsyncCount = s.hsyncCount + 2'h1;
      end
    end

    // ---------------------------------------------------------------
    // reset of control state only; bounds and select stay undefined
    // ---------------------------------------------------------------
    if (!reset_n) begin
      next_s.dataPhase     = 1'b0;
      next_s.phaseWrite    = 1'b0;
      next_s.phaseIndex    = '0;
      next_s.compareEnable = COMPARE_ENABLE_RESET;
      next_s.keyPolarity   = KEY_POLARITY_RESET;
      next_s.readData      = '0;
      next_s.hsyncCount    = '0;
      next_s.retraceDone   = 1'b0;
      next_s.lastHsync     = 1'b0;
      next_s.pixelDiv      = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    s <= next_s;
  end

  // ----------------------------------------------------------------
  // engine drive
  // ----------------------------------------------------------------
  assign vid.advance  = pixelTick && !pixBlank && reset_n;
  assign vid.pixelBit = selectBit;
  assign vid.capture  = captureNow && reset_n;

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_comb begin
    for (int f = 0; f < FIELD_COUNT; f++) begin
      keyLower[f] = s.keyBound[2*f];
      keyUpper[f] = s.keyBound[2*f+1];
    end
  end

  assign compareEnable = s.compareEnable;
  assign keyPolarity   = s.keyPolarity;
  assign signature     = vid.signature;
  assign hrdata        = {24'h000000, s.readData};
  assign hreadyout     = 1'b1;
  assign hresp         = HRESP_OKAY;

endmodule

`default_nettype wire

// file: dv/ckcrc_top_chk.sv
/*
  checker for the key and signature block, watching top ports only.
  assumes hready is tied to hreadyout and single word transfers.
*/
`timescale 1ns/1ps
`default_nettype none

module ckcrc_top_chk
  import ckcrc_pkg::*;
(
  // clock and reset
  input wire logic                        ref_clk,
  input wire logic                        reset_n,
  // bus
  input wire logic                        hsel,
  input wire logic [31:0]                 haddr,
  input wire logic [1:0]                  htrans,
  input wire logic                        hwrite,
  input wire logic [2:0]                  hsize,
  input wire logic [31:0]                 hwdata,
  input wire logic                        hready,
  input wire logic [31:0]                 hrdata,
  input wire logic                        hreadyout,
  input wire logic                        hresp,
  // video and settings
  input wire logic [DAC_WIDTH-1:0]        vidData,
  input wire logic                        vidHsync,
  input wire logic                        vidBlank,
  input wire logic [FIELD_COUNT-1:0][7:0] keyLower,
  input wire logic [FIELD_COUNT-1:0][7:0] keyUpper,
  input wire logic [FIELD_COUNT-1:0]      compareEnable,
  input wire logic                        keyPolarity,
  input wire logic [CRC_WIDTH-1:0]        signature
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // ------
  // bus steps
  // ------
  sequence s_take(logic [7:0] idx, logic wr);
    hsel && hready && htrans == HTRANS_NONSEQ && hwrite == wr && haddr[9:2] == idx;
  endsequence
  sequence s_write(logic [7:0] idx);
    s_take(idx, 1'b1) ##1 1'b1;
  endsequence

  a_bus_okay: assert property (hreadyout && hresp == HRESP_OKAY) else $error("bus not ready or not okay");
  a_rdata_upper: assert property (hrdata[31:8] == 24'h0) else $error("read data upper bits set");
  a_lower_store: assert property (s_write(IDX_OVERLAY_KEY_LOWER) |=> keyLower[0] == $past(hwdata[7:0]))
    else $error("overlay lower bound not stored");
  a_upper_store: assert property (s_write(IDX_BLUE_KEY_UPPER) |=> keyUpper[3] == $past(hwdata[7:0]))
    else $error("blue upper bound not stored");
  a_ctrl_store: assert property (s_write(IDX_KEY_CONTROL) |=>
    compareEnable == $past(hwdata[3:0]) && keyPolarity == $past(hwdata[4])) else $error("key control not stored");
  a_sig_low: assert property (s_take(IDX_SIGNATURE_LOW_BYTE, 1'b0) |=>
    hrdata == {24'h0, $past(signature[7:0])}) else $error("signature low byte wrong");
  a_sig_high: assert property (s_take(IDX_SIGNATURE_HIGH_BYTE, 1'b0) |=>
    hrdata == {24'h0, $past(signature[15:8])}) else $error("signature high byte wrong");
  a_select_hidden: assert property (s_take(IDX_SIGNATURE_LINE_SELECT, 1'b0) |=> hrdata == 32'h0)
    else $error("line select readable");
  a_reset_defaults: assert property ($rose(reset_n) |->
    compareEnable == COMPARE_ENABLE_RESET && keyPolarity == KEY_POLARITY_RESET) else $error("key control reset wrong");
  a_sig_in_blank: assert property ($changed(signature) |-> $past(vidBlank, 3) && $past(vidBlank, 6))
    else $error("signature changed outside blanking");
endmodule

bind ckcrc_top ckcrc_top_chk i_chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .vidData(vidData), .vidHsync(vidHsync), .vidBlank(vidBlank), .keyLower(keyLower), .keyUpper(keyUpper),
  .compareEnable(compareEnable), .keyPolarity(keyPolarity), .signature(signature)
);

`default_nettype wire

// file: dv/ckcrc_vid_src.sv
/*
  video source model: active lines, line retrace and frame retrace.
  assumes pins change right after a ref_clk edge.
*/
`timescale 1ns/1ps
`default_nettype none

module ckcrc_vid_src
  import ckcrc_pkg::*;
#(
  parameter int NACT = 12
) (
  // clock
  input wire logic                  ref_clk,
  // video pins
  output logic     [DAC_WIDTH-1:0]  vidData,
  output logic                      vidHsync,
  output logic                      vidBlank
);
  initial begin
    vidData = '0;
    vidHsync = 1'b0;
    vidBlank = 1'b1;
  end

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // sync pulse inside blanking
  task automatic pulse;
    vidHsync <= 1'b1;
    step(3);
    vidHsync <= 1'b0;
    step(3);
  endtask

  // active line, then blanking with changing data and one sync
  task automatic line(input logic [DAC_WIDTH-1:0] d);
    vidData <= d;
    step(1);
    vidBlank <= 1'b0;
    step(NACT);
    vidBlank <= 1'b1;
    step(1);
    vidData <= ~d;
    pulse;
  endtask

  // two lines, then two syncs in one blanking period
  task automatic frame(input logic [DAC_WIDTH-1:0] d0, input logic [DAC_WIDTH-1:0] d1);
    line(d0);
    line(d1);
    pulse;
    pulse;
    step(6);
  endtask
endmodule

`default_nettype wire

// file: dv/tb.sv
/*
  testbench: key registers, key control and signature over the bus.
  assumes the checker is bound and the video model drives the pins.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import ckcrc_pkg::*;
  localparam int NACT = 12;
  localparam logic [23:0] D0 = 24'ha5c33c;
  localparam logic [23:0] D1 = 24'h5a0ff1;
  logic                        ref_clk;
  logic                        reset_n;
  logic                        hsel;
  logic                        hwrite;
  logic [1:0]                  htrans;
  logic [31:0]                 haddr;
  logic [31:0]                 hwdata;
  logic [31:0]                 hrdata;
  logic [31:0]                 rd;
  logic                        hreadyout;
  logic                        hresp;
  logic [DAC_WIDTH-1:0]        vidData;
  logic                        vidHsync;
  logic                        vidBlank;
  logic [FIELD_COUNT-1:0][7:0] keyLower;
  logic [FIELD_COUNT-1:0][7:0] keyUpper;
  logic [FIELD_COUNT-1:0]      compareEnable;
  logic                        keyPolarity;
  logic [CRC_WIDTH-1:0]        signature;
  logic [CRC_WIDTH-1:0]        expSig;
  logic [7:0]                  keyVal [8] = '{8'h00, 8'hff, 8'h01, 8'hfe, 8'h80, 8'h7f, 8'h5a, 8'ha5};
  logic [4:0]                  codes [4] = '{5'h00, 5'h0f, 5'h17, 5'h0a};
  int                          err_total = 0;
  int                          comparisons = 0;

  ckcrc_top #(.CRC_POLY(CRC_POLY_DEFAULT), .CRC_SEED(CRC_SEED_DEFAULT), .PIXEL_DIVIDE(8'h01)) i_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .vidData(vidData), .vidHsync(vidHsync), .vidBlank(vidBlank), .keyLower(keyLower), .keyUpper(keyUpper),
    .compareEnable(compareEnable), .keyPolarity(keyPolarity), .signature(signature)
  );

  ckcrc_vid_src #(.NACT(NACT)) i_vid (.ref_clk(ref_clk), .vidData(vidData), .vidHsync(vidHsync), .vidBlank(vidBlank));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ------
  // helpers
  // ------
  task finish_test;
    if (err_total == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      err_total++;
    end
  endtask

  task wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      err_total++;
      finish_test;
    end
  endtask

  task bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_ready;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready;
    rd = hrdata;
  endtask

  task rdchk(input logic [7:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    check(rd, exp);
  endtask

  // serial signature of one frame, msb first
  function automatic logic [15:0] crc_frame(input logic [4:0] code);
    logic [15:0] c;
    logic        b;
    c = CRC_SEED_DEFAULT;
    for (int n = 0; n < 2 * NACT; n++) begin
      b = (n < NACT) ? D0[code] : D1[code];
      c = {c[14:0], 1'b0} ^ ((b ^ c[15]) ? CRC_POLY_DEFAULT : 16'h0);
    end
    return c;
  endfunction

  // ------
  // main sequence
  // ------
  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    check({27'h0, keyPolarity, compareEnable}, 32'h10);
    rdchk(IDX_KEY_CONTROL, 32'h10);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, IDX_OVERLAY_KEY_LOWER + 8'(i), {24'h0, keyVal[i]});
    end
    for (int i = 0; i < 8; i++) begin
      rdchk(IDX_OVERLAY_KEY_LOWER + 8'(i), {24'h0, keyVal[i]});
      check({24'h0, i[0] ? keyUpper[i / 2] : keyLower[i / 2]}, {24'h0, keyVal[i]});
    end
    bus(1'b1, IDX_KEY_CONTROL, 32'h0f);
    @(negedge ref_clk);
    check({27'h0, keyPolarity, compareEnable}, 32'h0f);
    rdchk(IDX_KEY_CONTROL, 32'h0f);
    for (int c = 0; c < 4; c++) begin
      bus(1'b1, IDX_SIGNATURE_LINE_SELECT, {27'h0, codes[c]});
      rdchk(IDX_SIGNATURE_LINE_SELECT, 32'h0);
      expSig = crc_frame(codes[c]);
      i_vid.frame(D0, D1);
      fork
        i_vid.frame(D0, D1);
        begin
          repeat (NACT) @(posedge ref_clk);
          rdchk(IDX_SIGNATURE_LOW_BYTE, {24'h0, expSig[7:0]});
        end
      join
      check({16'h0, signature}, {16'h0, expSig});
      rdchk(IDX_SIGNATURE_LOW_BYTE, {24'h0, expSig[7:0]});
      rdchk(IDX_SIGNATURE_HIGH_BYTE, {24'h0, expSig[15:8]});
      bus(1'b1, IDX_SIGNATURE_LOW_BYTE, 32'hff);
      rdchk(IDX_SIGNATURE_LOW_BYTE, {24'h0, expSig[7:0]});
    end
    finish_test;
  end
endmodule

`default_nettype wire
